//--- asu_core.sv
// async serial unit: register slave, port 1 pin sharing, transmitter and receiver
`timescale 1ns/1ps
`include "asu_consts.svh"

module asu_core (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire asu_pkg::asu_avm_req_s i_avm,
  output logic                       o_avm_waitrequest,
  output logic [31:0]                o_avm_readdata,
  input  wire logic [7:0]            i_port1_in,
  output logic [7:0]                 o_port1_out,
  output logic [7:0]                 o_port1_oe
);
  import asu_pkg::*;

  asu_state_s st_ff;
  asu_state_s nxt_st;

  // reverse bit order of a character so the shifter always sends bit 0
  function automatic logic [7:0] rev_char(input logic [7:0] d, input logic len8);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return len8 ? r : {1'b0, r[7:1]};
  endfunction

  // ----------------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------------
  logic       pwr;
  logic       tx_run;
  logic       rx_run;
  logic       len8;
  logic       stop2;
  logic       lsb_first;
  asu_par_e   par_sel;
  logic [7:0] bit_per;
  logic       rx_line;
  logic       tx_bit;
  logic       wr_acc;
  logic       rd_acc;

  assign pwr       = st_ff.mode[`ASU_MODE_POWER];
  assign tx_run    = pwr & st_ff.mode[`ASU_MODE_TXEN];
  assign rx_run    = pwr & st_ff.mode[`ASU_MODE_RXEN];
  assign len8      = st_ff.mode[`ASU_MODE_CHLEN];
  assign stop2     = st_ff.mode[`ASU_MODE_STOP];
  assign par_sel   = asu_par_e'(st_ff.mode[`ASU_MODE_PAR_HI:`ASU_MODE_PAR_LO]);
  assign lsb_first = st_ff.ctrl[`ASU_CTRL_ORDER];
  // a divisor below the minimum would give no room for a mid-bit sample
  assign bit_per   = (st_ff.baud < `ASU_BAUD_MIN) ? `ASU_BAUD_MIN : st_ff.baud;
  // receive input held high while powered down
  assign rx_line   = pwr ? st_ff.pin_s2[`ASU_RX_PIN] : 1'b1;
  // the bus answers one cycle after the request appears
  assign wr_acc    = i_avm.write & ~st_ff.wait_req;
  assign rd_acc    = i_avm.read & ~st_ff.wait_req;

  // line level of the transmitter for the current state
  always_comb begin
    case (st_ff.tx_st)
      TX_START: tx_bit = 1'b0;
      TX_DATA:  tx_bit = st_ff.tx_sh[0];
      TX_PAR:   tx_bit = st_ff.tx_par;
      default:  tx_bit = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // pin synchroniser, two stages before any use
    nxt_st.pin_s1 = i_port1_in;
    nxt_st.pin_s2 = st_ff.pin_s1;

    // bus handshake: waitrequest low for exactly one cycle per request
    nxt_st.wait_req = ~((i_avm.read | i_avm.write) & st_ff.wait_req);
    nxt_st.rdata    = 32'h0000_0000;
    if ((i_avm.read | i_avm.write) & st_ff.wait_req & i_avm.read) begin
      case (i_avm.address)
        `ASU_OFS_OPMODE:  nxt_st.rdata[7:0] = st_ff.mode;
        `ASU_OFS_CTRL:    nxt_st.rdata[7:0] = st_ff.ctrl & `ASU_CTRL_MASK;
        `ASU_OFS_P1DIR:   nxt_st.rdata[7:0] = st_ff.p1dir;
        `ASU_OFS_P1LATCH: nxt_st.rdata[7:0] = st_ff.p1latch;
        `ASU_OFS_P1PINS:  nxt_st.rdata[7:0] = st_ff.pin_s2;
        `ASU_OFS_TXBUF:   nxt_st.rdata[7:0] = st_ff.txbuf;
        `ASU_OFS_RXBUF:   nxt_st.rdata[7:0] = st_ff.rxbuf;
        `ASU_OFS_RXERR:   nxt_st.rdata[2:0] = st_ff.rxerr;
        `ASU_OFS_TXSTAT:  nxt_st.rdata[1:0] = {st_ff.tx_bfull, st_ff.tx_sfull};
        `ASU_OFS_BAUD:    nxt_st.rdata[7:0] = st_ff.baud;
        default:          nxt_st.rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end

    // read side effects come first so a same-cycle hardware set wins
    if (rd_acc && i_avm.address == `ASU_OFS_RXBUF) begin
      nxt_st.rx_full = 1'b0;
    end
    if (rd_acc && i_avm.address == `ASU_OFS_RXERR) begin
      nxt_st.rxerr = 3'h0;
    end

    // register writes
    if (wr_acc) begin
      case (i_avm.address)
        `ASU_OFS_OPMODE:  nxt_st.mode    = i_avm.writedata[7:0];
        `ASU_OFS_CTRL:    nxt_st.ctrl    = i_avm.writedata[7:0] & `ASU_CTRL_MASK;
        `ASU_OFS_P1DIR:   nxt_st.p1dir   = i_avm.writedata[7:0];
        `ASU_OFS_P1LATCH: nxt_st.p1latch = i_avm.writedata[7:0];
        `ASU_OFS_BAUD:    nxt_st.baud    = i_avm.writedata[7:0];
        default:          nxt_st.mode    = st_ff.mode;  // transmit buffer handled below, the rest ignored
      endcase
    end

    // power dropped during a frame: park the tx pin high until tx is disabled or power returns
    if (wr_acc && i_avm.address == `ASU_OFS_OPMODE && st_ff.tx_sfull &&
        !i_avm.writedata[`ASU_MODE_POWER]) begin
      nxt_st.tx_hold = 1'b1;
    end else if (pwr || !st_ff.mode[`ASU_MODE_TXEN]) begin
      nxt_st.tx_hold = 1'b0;
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    if (!tx_run) begin
      nxt_st.tx_st    = TX_IDLE;
      nxt_st.tx_bfull = 1'b0;
      nxt_st.tx_sfull = 1'b0;
      nxt_st.tx_tmr   = 8'h00;
    end else if (st_ff.tx_st == TX_IDLE) begin
      if (st_ff.tx_bfull) begin
        // buffer moves to the shifter; the buffer is free again at once
        nxt_st.tx_word  = len8 ? st_ff.txbuf : {1'b0, st_ff.txbuf[6:0]};
        nxt_st.tx_sh    = lsb_first ? nxt_st.tx_word
                                    : rev_char(st_ff.txbuf, len8);
        nxt_st.tx_par   = (par_sel == ASU_PAR_EVEN) ? ^nxt_st.tx_word :
                          (par_sel == ASU_PAR_ODD)  ? ~^nxt_st.tx_word : 1'b0;
        nxt_st.tx_bfull = 1'b0;
        nxt_st.tx_sfull = 1'b1;
        nxt_st.tx_st    = TX_START;
        nxt_st.tx_tmr   = bit_per - 8'h01;
      end
    end else if (st_ff.tx_tmr != 8'h00) begin
      nxt_st.tx_tmr = st_ff.tx_tmr - 8'h01;
    end else begin
      nxt_st.tx_tmr = bit_per - 8'h01;
      case (st_ff.tx_st)
        TX_START: begin
          nxt_st.tx_st  = TX_DATA;
          nxt_st.tx_cnt = len8 ? 4'h7 : 4'h6;
        end
        TX_DATA: begin
          nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
          nxt_st.tx_cnt = st_ff.tx_cnt - 4'h1;
          if (st_ff.tx_cnt == 4'h0) begin
            nxt_st.tx_st  = (par_sel == ASU_PAR_NONE) ? TX_STOP : TX_PAR;
            nxt_st.tx_cnt = {3'h0, stop2};
          end
        end
        TX_PAR: begin
          nxt_st.tx_st  = TX_STOP;
          nxt_st.tx_cnt = {3'h0, stop2};
        end
        TX_STOP: begin
          nxt_st.tx_cnt = st_ff.tx_cnt - 4'h1;
          if (st_ff.tx_cnt == 4'h0) begin
            nxt_st.tx_st    = TX_IDLE;
            nxt_st.tx_sfull = 1'b0;
          end
        end
        default: nxt_st.tx_st = TX_IDLE;
      endcase
    end
    // a buffer write while full overwrites; software checks the full flag first
    if (wr_acc && i_avm.address == `ASU_OFS_TXBUF && tx_run) begin
      nxt_st.txbuf    = i_avm.writedata[7:0];
      nxt_st.tx_bfull = 1'b1;
    end

    // ------------------------------------------------------------------
    // receiver, runs independently of the transmitter
    // ------------------------------------------------------------------
    if (!rx_run) begin
      nxt_st.rx_st  = RX_IDLE;
      nxt_st.rx_tmr = 8'h00;
    end else if (st_ff.rx_st == RX_IDLE) begin
      if (!rx_line) begin
        nxt_st.rx_st   = RX_START;
        nxt_st.rx_tmr  = {1'b0, bit_per[7:1]};
        nxt_st.rx_sh   = 8'h00;
        nxt_st.rx_ones = 1'b0;
      end
    end else if (st_ff.rx_tmr != 8'h00) begin
      nxt_st.rx_tmr = st_ff.rx_tmr - 8'h01;
    end else begin
      nxt_st.rx_tmr = bit_per - 8'h01;
      case (st_ff.rx_st)
        RX_START: begin
          // a high mid-start sample is a glitch, not a frame
          nxt_st.rx_st  = rx_line ? RX_IDLE : RX_DATA;
          nxt_st.rx_cnt = len8 ? 4'h7 : 4'h6;
        end
        RX_DATA: begin
          nxt_st.rx_sh   = lsb_first ? {rx_line, st_ff.rx_sh[7:1]}
                                     : {st_ff.rx_sh[6:0], rx_line};
          nxt_st.rx_ones = st_ff.rx_ones ^ rx_line;
          nxt_st.rx_cnt  = st_ff.rx_cnt - 4'h1;
          if (st_ff.rx_cnt == 4'h0) begin
            nxt_st.rx_st = (par_sel == ASU_PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          nxt_st.rx_ones = st_ff.rx_ones ^ rx_line;
          nxt_st.rx_st   = RX_STOP;
        end
        RX_STOP: begin
          // only the first stop bit is checked on receive
          nxt_st.rx_st = RX_IDLE;
          if (!rx_line) begin
            nxt_st.rxerr[`ASU_ERR_FE] = 1'b1;
          end
          if ((par_sel == ASU_PAR_EVEN && st_ff.rx_ones) ||
              (par_sel == ASU_PAR_ODD && !st_ff.rx_ones)) begin
            nxt_st.rxerr[`ASU_ERR_PE] = 1'b1;
          end
          if (st_ff.rx_full) begin
            nxt_st.rxerr[`ASU_ERR_OVE] = 1'b1;  // overrun keeps the old byte
          end else begin
            nxt_st.rxbuf   = len8 ? st_ff.rx_sh :
                             (lsb_first ? {1'b0, st_ff.rx_sh[7:1]}
                                        : {1'b0, st_ff.rx_sh[6:0]});
            nxt_st.rx_full = 1'b1;
          end
        end
        default: nxt_st.rx_st = RX_IDLE;
      endcase
    end

    // power off clears status, receive buffer and both engines
    if (!pwr) begin
      nxt_st.rxerr    = 3'h0;
      nxt_st.rxbuf    = 8'h00;
      nxt_st.rx_full  = 1'b0;
      nxt_st.tx_bfull = 1'b0;
      nxt_st.tx_sfull = 1'b0;
      nxt_st.tx_sh    = 8'h00;
      nxt_st.rx_sh    = 8'h00;
    end

    // pins: direction always from the direction register, port latch unless the transmitter owns pin 3
    nxt_st.pins.oe  = ~st_ff.p1dir;
    nxt_st.pins.out = st_ff.p1latch;
    if (st_ff.tx_hold) begin
      nxt_st.pins.out[`ASU_TX_PIN] = 1'b1;
    end else if (tx_run) begin
      nxt_st.pins.out[`ASU_TX_PIN] = tx_bit ^ st_ff.ctrl[`ASU_CTRL_INV];
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff          <= '0;
      st_ff.mode     <= `ASU_RST_OPMODE;
      st_ff.ctrl     <= `ASU_RST_CTRL & `ASU_CTRL_MASK;
      st_ff.p1dir    <= `ASU_RST_P1DIR;
      st_ff.p1latch  <= `ASU_RST_P1LATCH;
      st_ff.baud     <= `ASU_RST_BAUD;
      st_ff.tx_st    <= TX_IDLE;
      st_ff.rx_st    <= RX_IDLE;
      st_ff.pin_s1   <= 8'hff;
      st_ff.pin_s2   <= 8'hff;
      st_ff.wait_req <= 1'b1;
      st_ff.pins.out <= `ASU_RST_P1LATCH;
      st_ff.pins.oe  <= ~`ASU_RST_P1DIR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_avm_waitrequest = st_ff.wait_req;
  assign o_avm_readdata    = st_ff.rdata;
  assign o_port1_out       = st_ff.pins.out;
  assign o_port1_oe        = st_ff.pins.oe;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_txbuf_wr;
    wr_acc && i_avm.address == `ASU_OFS_TXBUF && tx_run && st_ff.tx_st == TX_IDLE;
  endsequence
  sequence s_frame_go;
    ##[1:2] st_ff.tx_st == TX_START;
  endsequence

  AST_DIR_RESET: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> st_ff.p1dir == 8'hff && o_port1_oe == 8'h00)
    else $error("direction register not all ones after reset");
  AST_MODE_RESET: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> st_ff.mode == 8'h01)
    else $error("mode register reset value wrong");
  AST_PIN_OE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    1'b1 |=> o_port1_oe == ~$past(st_ff.p1dir))
    else $error("pin enable does not follow direction");
  AST_PORT_FN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !tx_run && !st_ff.tx_hold |=> o_port1_out[3] == $past(st_ff.p1latch[3]))
    else $error("tx pin not port latch while disabled");
  AST_PWR_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !pwr |=> st_ff.rxerr == 3'h0 && !st_ff.tx_bfull && !st_ff.rx_full)
    else $error("power off left status set");
  AST_TX_OFF: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !tx_run |=> st_ff.tx_st == TX_IDLE && !st_ff.tx_sfull)
    else $error("transmitter running while disabled");
  AST_RX_OFF: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !rx_run |=> st_ff.rx_st == RX_IDLE)
    else $error("receiver running while disabled");
  AST_TX_START: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    s_txbuf_wr |-> s_frame_go)
    else $error("buffer write did not start a frame");
  AST_START_LOW: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_ff.tx_st == TX_START && tx_run && !st_ff.ctrl[0] |=> o_port1_out[3] == 1'b0)
    else $error("start bit not low");
  AST_INVERT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    tx_run && !st_ff.tx_hold && st_ff.ctrl[0] |=> o_port1_out[3] == ~$past(tx_bit))
    else $error("inverted output wrong");
  // parity is judged against the buffer that was loaded, not the shifter's own copy
  AST_EVEN_TX: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_ff.tx_st == TX_IDLE && st_ff.tx_bfull && tx_run && par_sel == ASU_PAR_EVEN |=>
      st_ff.tx_par == ^($past(st_ff.txbuf) & ($past(len8) ? 8'hff : 8'h7f)))
    else $error("even parity bit wrong");
  AST_EVEN_RX: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    rx_run && st_ff.rx_st == RX_STOP && st_ff.rx_tmr == 8'h00 &&
    par_sel == ASU_PAR_EVEN && st_ff.rx_ones |=> st_ff.rxerr[2])
    else $error("even parity error not flagged");
  AST_HOLD_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st_ff.tx_hold |=> o_port1_out[3] == 1'b1)
    else $error("tx pin not high after power loss");

endmodule

//--- asu_consts.svh
// register offsets, reset values, field positions and timing figures of the serial unit
`ifndef ASU_CONSTS_SVH
`define ASU_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ASU_OFS_OPMODE   16'hff50
`define ASU_OFS_CTRL     16'hff58
`define ASU_OFS_P1DIR    16'hff20
`define ASU_OFS_P1LATCH  16'hff24
`define ASU_OFS_P1PINS   16'hff28
`define ASU_OFS_TXBUF    16'hff60
`define ASU_OFS_RXBUF    16'hff64
`define ASU_OFS_RXERR    16'hff68
`define ASU_OFS_TXSTAT   16'hff6c
`define ASU_OFS_BAUD     16'hff70

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ASU_RST_OPMODE   8'h01
`define ASU_RST_CTRL     8'h16
`define ASU_RST_P1DIR    8'hff
`define ASU_RST_P1LATCH  8'h00
`define ASU_RST_BAUD     8'hff

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASU_MODE_POWER   7
`define ASU_MODE_TXEN    6
`define ASU_MODE_RXEN    5
`define ASU_MODE_PAR_HI  4
`define ASU_MODE_PAR_LO  3
`define ASU_MODE_CHLEN   2
`define ASU_MODE_STOP    1
`define ASU_CTRL_ORDER   1
`define ASU_CTRL_INV     0
`define ASU_CTRL_MASK    8'h3f
`define ASU_TX_PIN       3
`define ASU_RX_PIN       4
`define ASU_ERR_PE       2
`define ASU_ERR_FE       1
`define ASU_ERR_OVE      0

// ----------------------------------------------------------------------
// timing: shortest bit period in clock cycles
// ----------------------------------------------------------------------
`define ASU_BAUD_MIN     8'h02

`endif

//--- asu_pkg.sv
// types shared by the serial unit
package asu_pkg;

  // parity select codes: none, zero, odd, even
  typedef enum logic [1:0] {
    ASU_PAR_NONE,
    ASU_PAR_ZERO,
    ASU_PAR_ODD,
    ASU_PAR_EVEN
  } asu_par_e;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PAR,
    TX_STOP
  } asu_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP
  } asu_rx_e;

  // avalon-mm slave request
  typedef struct packed {
    logic [15:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } asu_avm_req_s;

  // port 1 pin group (output, output enable)
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } asu_pins_s;

  // whole state of the unit
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    logic [7:0]  p1dir;
    logic [7:0]  p1latch;
    logic [7:0]  baud;
    logic [7:0]  txbuf;
    logic [7:0]  rxbuf;
    logic [2:0]  rxerr;
    logic        tx_bfull;
    logic        tx_sfull;
    logic        tx_hold;
    logic        rx_full;
    asu_tx_e     tx_st;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_word;
    logic        tx_par;
    logic [3:0]  tx_cnt;
    logic [7:0]  tx_tmr;
    asu_rx_e     rx_st;
    logic [7:0]  rx_sh;
    logic        rx_ones;
    logic [3:0]  rx_cnt;
    logic [7:0]  rx_tmr;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic        wait_req;
    logic [31:0] rdata;
    asu_pins_s   pins;
  } asu_state_s;

endpackage

//--- asu_remote_node.sv
// remote serial node model: captures frames from the link and sends frames onto it
`timescale 1ns/1ps

module asu_remote_node #(
  parameter int BIT_CYC = 4
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_line,
  input  wire logic [3:0]  i_len,
  output logic             o_line,
  output logic [11:0]      o_frame,
  output logic [7:0]       o_cnt
);
  logic [11:0] cap;

  initial begin
    o_line  = 1'b1;
    o_frame = 12'h000;
    o_cnt   = 8'h00;
  end

  // capture: a low level opens a frame, then every bit is sampled mid-period
  always begin
    do begin
      @(posedge i_sys_clk);
    end while (i_line !== 1'b0);
    cap = 12'h000;
    repeat (BIT_CYC / 2) @(posedge i_sys_clk);
    for (int k = 0; k < i_len; k++) begin
      cap[k] = i_line;
      repeat (BIT_CYC) @(posedge i_sys_clk);
    end
    o_frame = cap;
    o_cnt   = o_cnt + 8'h01;
  end

  // send: one level per bit period, start bit first, then back to idle high
  task automatic send(input logic [11:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      o_line <= f[k];
      repeat (BIT_CYC) @(posedge i_sys_clk);
    end
    o_line <= 1'b1;
  endtask
endmodule

//--- async_serial_unit_core_test.sv
// self-checking bench of the serial unit core against a remote node model
`timescale 1ns/1ps
`include "asu_consts.svh"

module async_serial_unit_core_test;
  import asu_pkg::*;
  logic          i_sys_clk;
  logic          i_sys_rst;
  asu_avm_req_s  req;
  logic          wait_req;
  logic [31:0]   rdata;
  logic [7:0]    p_out;
  logic [7:0]    p_oe;
  logic [7:0]    p_in;
  logic          tx_line;
  logic          inv;
  logic          mon_on;
  logic [3:0]    peer_len;
  logic          peer_line;
  logic [11:0]   peer_frame;
  logic [7:0]    peer_cnt;
  int            error_cnt;
  int            checks;
  int            cyc;

  // undriven pins sit on a pull-up; pin 4 carries the remote node while released
  assign tx_line = p_oe[3] ? p_out[3] : 1'b1;
  assign p_in    = (p_oe & p_out) | (~p_oe & {3'h7, peer_line, 4'hf});

  asu_core dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_avm(req),
    .o_avm_waitrequest(wait_req), .o_avm_readdata(rdata), .i_port1_in(p_in),
    .o_port1_out(p_out), .o_port1_oe(p_oe));

  // the monitor sees the uninverted line only while a frame is expected
  asu_remote_node #(.BIT_CYC(4)) peer_u (.i_sys_clk(i_sys_clk),
    .i_line(mon_on ? tx_line ^ inv : 1'b1), .i_len(peer_len), .o_line(peer_line),
    .o_frame(peer_frame), .o_cnt(peer_cnt));

  initial i_sys_clk = 1'b0;
  always #12.5 i_sys_clk = ~i_sys_clk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle: request held until waitrequest is sampled low, data taken there
  task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge i_sys_clk);
    req <= '{a, ~we, we, {24'h000000, d}};
    // no local limit: only the hang guard ends a wait
    do begin
      @(posedge i_sys_clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    req <= '{a, 1'b0, 1'b0, {24'h000000, d}};
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  // expected frame, start bit at index 0, built from mode and control fields
  function automatic logic [11:0] fr_make(input logic [7:0] m, c, d, output int n);
    logic [11:0] f;
    int          nb;
    logic        p;
    nb = m[2] ? 8 : 7;
    f  = 12'h000;
    n  = 1;
    for (int i = 0; i < nb; i++) begin
      f[n] = c[1] ? d[i] : d[nb-1-i];
      n++;
    end
    p = ^(d & (m[2] ? 8'hff : 8'h7f));
    if (m[4:3] != 2'b00) begin
      f[n] = (m[4:3] == 2'b11) ? p : ((m[4:3] == 2'b10) ? ~p : 1'b0);
      n++;
    end
    f[n] = 1'b1;
    n++;
    if (m[1]) begin
      f[n] = 1'b1;
      n++;
    end
    return f;
  endfunction

  task automatic t_reset();
    chk({24'h0, p_oe}, 32'h0);
    rdc(`ASU_OFS_OPMODE, 32'h01);
    rdc(`ASU_OFS_P1DIR, 32'hff);
    rdc(`ASU_OFS_CTRL, 32'h16);
    rdc(16'hff00, 32'h0);
    wr(`ASU_OFS_BAUD, 8'h04);
    wr(`ASU_OFS_P1DIR, 8'hf7);
    repeat (3) @(posedge i_sys_clk);
    chk({24'h0, p_oe}, 32'h08);
    chk({31'h0, p_out[3]}, 32'h0);
    wr(`ASU_OFS_P1LATCH, 8'h08);
    repeat (3) @(posedge i_sys_clk);
    chk({31'h0, p_out[3]}, 32'h1);
  endtask

  // configure, enable in the documented order, send one byte, compare the frame
  task automatic tx_case(input logic [7:0] cfg, c, d);
    logic [11:0] e;
    int          n;
    logic [7:0]  k0;
    // enables drop before power, frame fields are set before power comes back
    wr(`ASU_OFS_OPMODE, 8'h80);
    wr(`ASU_OFS_OPMODE, cfg);
    wr(`ASU_OFS_CTRL, c);
    wr(`ASU_OFS_OPMODE, cfg | 8'h80);
    wr(`ASU_OFS_OPMODE, cfg | 8'hc0);
    inv = c[0];
    repeat (3) @(posedge i_sys_clk);
    mon_on = 1'b1;
    e = fr_make(cfg, c, d, n);
    peer_len = n[3:0];
    k0 = peer_cnt;
    wr(`ASU_OFS_TXBUF, d);
    while (peer_cnt == k0) begin
      @(posedge i_sys_clk);
    end
    chk({20'h0, peer_frame}, {20'h0, e});
    mon_on = 1'b0;
  endtask

  // power or transmit enable dropped in mid-frame
  task automatic t_abort();
    wr(`ASU_OFS_OPMODE, 8'h9c);
    wr(`ASU_OFS_OPMODE, 8'hdc);
    // latch low, so only the power-loss hold can keep the pin high
    wr(`ASU_OFS_P1LATCH, 8'h00);
    wr(`ASU_OFS_TXBUF, 8'h00);
    repeat (12) @(posedge i_sys_clk);
    wr(`ASU_OFS_OPMODE, 8'h5c);
    repeat (3) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      chk({31'h0, tx_line}, 32'h1);
      @(posedge i_sys_clk);
    end
    rdc(`ASU_OFS_TXSTAT, 32'h0);
    wr(`ASU_OFS_P1LATCH, 8'h08);
    wr(`ASU_OFS_OPMODE, 8'h9c);
    wr(`ASU_OFS_OPMODE, 8'hdc);
    wr(`ASU_OFS_TXBUF, 8'h00);
    repeat (6) @(posedge i_sys_clk);
    wr(`ASU_OFS_OPMODE, 8'h9c);
    repeat (2) @(posedge i_sys_clk);
    rdc(`ASU_OFS_TXSTAT, 32'h0);
  endtask

  // reception with good and bad even parity, then power-down clearing
  task automatic t_rx();
    logic [11:0] f;
    int          n;
    wr(`ASU_OFS_CTRL, 8'h02);
    wr(`ASU_OFS_OPMODE, 8'hbc);
    f = fr_make(8'h1c, 8'h02, 8'ha5, n);
    @(posedge i_sys_clk);
    peer_u.send(f, n);
    repeat (4) @(posedge i_sys_clk);
    rdc(`ASU_OFS_RXBUF, 32'ha5);
    rdc(`ASU_OFS_RXERR, 32'h0);
    @(posedge i_sys_clk);
    peer_u.send(f ^ 12'h200, n);
    repeat (4) @(posedge i_sys_clk);
    rdc(`ASU_OFS_RXERR, 32'h4);
    rdc(`ASU_OFS_RXBUF, 32'ha5);
    @(posedge i_sys_clk);
    peer_u.send(f ^ 12'h200, n);
    repeat (4) @(posedge i_sys_clk);
    wr(`ASU_OFS_OPMODE, 8'h9c);
    wr(`ASU_OFS_OPMODE, 8'h00);
    rdc(`ASU_OFS_RXERR, 32'h0);
    rdc(`ASU_OFS_RXBUF, 32'h0);
  endtask

  initial begin
    i_sys_rst = 1'b1;
    req       = '0;
    inv       = 1'b0;
    mon_on    = 1'b0;
    peer_len  = 4'hc;
    error_cnt = 0;
    checks    = 0;
    cyc       = 0;
    repeat (12) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    tx_case(8'h1c, 8'h02, 8'h55);
    tx_case(8'h1c, 8'h01, 8'h55);
    tx_case(8'h12, 8'h02, 8'h36);
    tx_case(8'h04, 8'h02, 8'h87);  // no parity bit in the frame
    tx_case(8'h0e, 8'h00, 8'hc3);
    t_abort();
    t_rx();
    print_verdict();
  end
endmodule
